// [hdl/dds_control_word_decoder.sv]
// Control word decode, frequency and phase word storage and output routing
`timescale 1ns/100ps
`default_nettype none
module dds_control_word_decoder (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// Word from the serial shifter, same clock
	input  wire logic                         word_valid,
	input  wire dcwd_pkg::dcwd_word_type      word_in,
	// Converter data MSB from the sine path
	input  wire logic                         conv_msb,
	// Selected words, delayed to match the output latency
	output dcwd_pkg::dcwd_nco_sel_type        nco_sel,
	// Control levels toward the datapath
	output logic                              accum_clear,
	output logic                              accum_clk_en,
	output logic                              converter_powerdown,
	output logic                              converter_to_pin,
	output logic                              ramp_mode,
	// Output pin bit when the MSB is routed out
	output logic                              pin_bit
);
	import dcwd_pkg::*;

	// Registered control word and its sampled copy
	dcwd_ctrl_type ctrl_q;
	dcwd_ctrl_type ctrl_smp_q;

	// Whole-word pairing state
	logic                 pend_valid_q;
	logic [ADDR_W-1:0]    pend_addr_q;
	logic [PAYLD_W-1:0]   pend_low_q;

	// Phase registers
	logic [PHASE_W-1:0]   phase_a_q;
	logic [PHASE_W-1:0]   phase_b_q;

	// Frequency registers
	logic [FREQ_W-1:0]    freq_a;
	logic [FREQ_W-1:0]    freq_b;

	// Decoded write kinds
	logic                 wr_ctrl;
	logic                 wr_freq;
	logic                 wr_phase;
	logic                 pair_done;

	// Per-register load strobes, index 0 is word a, 1 is word b
	logic [1:0]           ld_low;
	logic [1:0]           ld_high;
	logic [1:0]           ld_full;

	// Latency pipeline and halved MSB
	dcwd_nco_sel_type     sel_now;
	dcwd_nco_sel_type     pipe_q [LOAD_LATENCY];
	logic                 msb_prev_q;
	logic                 msb_half_q;

	// Address decode of the top two bits
	assign wr_ctrl  = word_valid && (word_in.addr == ADDR_CTRL);
	assign wr_freq  = word_valid &&
		((word_in.addr == ADDR_FREQA) || (word_in.addr == ADDR_FREQB));
	assign wr_phase = word_valid && (word_in.addr == ADDR_PHASE);

	// Second half of a pair: same address as the held first half
	assign pair_done = wr_freq && ctrl_q.whole_word_load && pend_valid_q &&
		(pend_addr_q == word_in.addr);

	// Load strobes for both frequency registers
	always_comb begin
		ld_low  = 2'h0;
		ld_high = 2'h0;
		ld_full = 2'h0;
		for (int i = 0; i < 2; i++) begin
			if (wr_freq && (word_in.addr == ((i == 0) ? ADDR_FREQA : ADDR_FREQB))) begin
				if (ctrl_q.whole_word_load) begin
					// half_select plays no part here
					ld_full[i] = pair_done;
				end else if (ctrl_q.half_select) begin
					ld_high[i] = 1'b1;
				end else begin
					ld_low[i] = 1'b1;
				end
			end
		end
	end

	// Control register: reserved bits are stored as written
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= dcwd_ctrl_type'(CTRL_RESET);
		end else if (wr_ctrl) begin
			ctrl_q <= dcwd_ctrl_type'(word_in.payload);
		end
	end

	// Control bits other than whole_word_load, half_select and ramp_mode act one stage after the write, like the falling-edge sample
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_smp_q <= dcwd_ctrl_type'(CTRL_RESET);
		end else begin
			ctrl_smp_q <= ctrl_q;
		end
	end

	// First half of a whole word waits here; any other write drops it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_valid_q <= 1'b0;
			pend_addr_q  <= ADDR_CTRL;
			pend_low_q   <= '0;
		end else if (word_valid) begin
			if (wr_freq && ctrl_q.whole_word_load && !pair_done) begin
				pend_valid_q <= 1'b1;
				pend_addr_q  <= word_in.addr;
				pend_low_q   <= word_in.payload;
			end else begin
				// Pending half is dropped if unpaired, or consumed by the pair load
				pend_valid_q <= 1'b0;
			end
		end else if (!ctrl_q.whole_word_load) begin
			pend_valid_q <= 1'b0;
		end
	end

	// Two frequency registers, one instance each
	dcwd_freq_reg u_freq_a (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load_low  (ld_low[0]),
		.load_high (ld_high[0]),
		.load_full (ld_full[0]),
		.low_data  (ld_full[0] ? pend_low_q : word_in.payload),
		.high_data (word_in.payload),
		.word_q    (freq_a)
	);

	dcwd_freq_reg u_freq_b (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load_low  (ld_low[1]),
		.load_high (ld_high[1]),
		.load_full (ld_full[1]),
		.low_data  (ld_full[1] ? pend_low_q : word_in.payload),
		.high_data (word_in.payload),
		.word_q    (freq_b)
	);

	// Phase registers take the low 12 payload bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_a_q <= '0;
			phase_b_q <= '0;
		end else if (wr_phase) begin
			if (word_in.payload[PHASE_SEL_BIT]) begin
				phase_b_q <= word_in.payload[PHASE_W-1:0];
			end else begin
				phase_a_q <= word_in.payload[PHASE_W-1:0];
			end
		end
	end

	// Word selection toward the accumulator and adder
	always_comb begin
		sel_now.freq  = ctrl_smp_q.freq_word_select ? freq_b : freq_a;
		sel_now.phase = ctrl_smp_q.phase_word_select ? phase_b_q : phase_a_q;
	end

	// Latency pipeline; frozen while halted so the output holds
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < LOAD_LATENCY; i++) begin
				pipe_q[i] <= '0;
			end
		end else if (!ctrl_smp_q.clock_halt) begin
			pipe_q[0] <= sel_now;
			for (int i = 1; i < LOAD_LATENCY; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	assign nco_sel = pipe_q[LOAD_LATENCY-1];

	// Halved MSB: toggles on each rising MSB while clock_halt is clear, cleared with the accumulator
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			msb_prev_q <= 1'b0;
			msb_half_q <= 1'b0;
		end else if (ctrl_smp_q.accum_reset) begin
			msb_prev_q <= 1'b0;
			msb_half_q <= 1'b0;
		end else if (!ctrl_smp_q.clock_halt) begin
			msb_prev_q <= conv_msb;
			if (conv_msb && !msb_prev_q) begin
				msb_half_q <= !msb_half_q;
			end
		end
	end

	// Level controls; halt is an enable rather than a gated clock
	assign accum_clear         = ctrl_smp_q.accum_reset;
	assign accum_clk_en        = !ctrl_smp_q.clock_halt;
	assign converter_powerdown = ctrl_smp_q.converter_powerdown;
	assign converter_to_pin    = !ctrl_smp_q.bit_output_route;

	// Mode bit skips the sample stage, so it acts one cycle earlier
	assign ramp_mode           = ctrl_q.ramp_mode;

	// Pin bit only meaningful while the MSB is routed out
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_bit <= 1'b0;
		end else if (ctrl_smp_q.bit_output_route) begin
			pin_bit <= ctrl_smp_q.msb_halving_bypass ? conv_msb : msb_half_q;
		end else begin
			pin_bit <= 1'b0;
		end
	end

endmodule : dds_control_word_decoder
`default_nettype wire

// [hdl/dcwd_pkg.sv]
// Constants, field layouts and carriers for the control word decoder
// Contract
// - Whole-word mode builds 28 bits from two writes
// - Register updates only after both halves arrive
// - Half mode: each write alters one half
// - half_select picks upper or lower half
// - half_select ignored while whole_word_load set
// - freq_word_select picks word a or b
// - phase_word_select picks phase register a or b
// - Reset bit holds accumulation at zero
// - clock_halt stops accumulator, output holds
// - converter_powerdown powers the converter down
// - bit_output_route drives pin with data MSB
// - Top bits 00 mean control write
// - Control bits sampled one stage later; ramp_mode, whole_word_load and half_select are used from the written register unsampled
// - Output follows new word after seven cycles
// - msb_halving_bypass chooses MSB or MSB halved
package dcwd_pkg;

	// Word layout
	localparam int WORD_W   = 16;
	localparam int ADDR_W   = 2;
	localparam int PAYLD_W  = 14;
	localparam int FREQ_W   = 28;
	localparam int PHASE_W  = 12;

	// Address codes in the top two bits
	localparam logic [1:0] ADDR_CTRL  = 2'h0;
	localparam logic [1:0] ADDR_FREQA = 2'h1;
	localparam logic [1:0] ADDR_FREQB = 2'h2;
	localparam logic [1:0] ADDR_PHASE = 2'h3;

	// Phase write: bit 13 selects the target, bit 12 is unused
	localparam int PHASE_SEL_BIT = 13;

	// Control reset value: reset bit set so the output starts quiet
	localparam logic [13:0] CTRL_RESET = 14'h0100;

	// Latency from a new selected word to its use downstream
	localparam int LOAD_LATENCY = 7;

	// Incoming 16-bit word
	typedef struct packed {
		logic [ADDR_W-1:0]  addr;
		logic [PAYLD_W-1:0] payload;
	} dcwd_word_type;

	// Control bits, bit 13 down to bit 0
	typedef struct packed {
		logic whole_word_load;
		logic half_select;
		logic freq_word_select;
		logic phase_word_select;
		logic rsvd9;
		logic accum_reset;
		logic clock_halt;
		logic converter_powerdown;
		logic bit_output_route;
		logic rsvd4;
		logic msb_halving_bypass;
		logic rsvd2;
		logic ramp_mode;
		logic rsvd0;
	} dcwd_ctrl_type;

	// Selected words toward the accumulator and phase adder
	typedef struct packed {
		logic [FREQ_W-1:0]  freq;
		logic [PHASE_W-1:0] phase;
	} dcwd_nco_sel_type;

endpackage : dcwd_pkg

// [hdl/dcwd_freq_reg.sv]
// One 28-bit frequency register with half and whole loads
`timescale 1ns/100ps
`default_nettype none
module dcwd_freq_reg (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// Load strobes and data
	input  wire logic                         load_low,
	input  wire logic                         load_high,
	input  wire logic                         load_full,
	input  wire logic [dcwd_pkg::PAYLD_W-1:0] low_data,
	input  wire logic [dcwd_pkg::PAYLD_W-1:0] high_data,
	// Stored word
	output logic      [dcwd_pkg::FREQ_W-1:0]  word_q
);
	import dcwd_pkg::*;

	// Full load writes both halves in one edge, so no partial value shows
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			word_q <= '0;
		end else if (load_full) begin
			word_q <= {high_data, low_data};
		end else begin
			if (load_high) begin
				word_q[FREQ_W-1:PAYLD_W] <= high_data;
			end
			if (load_low) begin
				word_q[PAYLD_W-1:0] <= low_data;
			end
		end
	end

endmodule : dcwd_freq_reg
`default_nettype wire

// [testbench/dcwd_host_model.sv]
// Host model that writes words into the decoder
`timescale 1ns/100ps
`default_nettype none
module dcwd_host_model (
	// Clock
	input  wire logic                   clk,
	// Word port
	output var logic                    word_valid,
	output var dcwd_pkg::dcwd_word_type word_in
);
	import dcwd_pkg::*;
	// Quiet port before the first word
	initial begin
		word_valid = 1'b0;
		word_in = '0;
	end
	// One-cycle pulse, address on top, low half sent first
	task send(input logic [15:0] w);
		@(negedge clk);
		word_valid = 1'b1;
		word_in = (w[15:14] == ADDR_CTRL) ? (w & 16'hfdff) : w;
		@(negedge clk);
		word_valid = 1'b0;
		word_in = ~word_in; // Stale word never looks fresh
	endtask : send
endmodule : dcwd_host_model
`default_nettype wire

// [testbench/dcwd_checker.sv]
// Port assertions for the control word decoder
`timescale 1ns/100ps
`default_nettype none
module dcwd_checker (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       sys_rst,
	// Inputs
	input wire logic                       word_valid,
	input wire dcwd_pkg::dcwd_word_type    word_in,
	input wire logic                       conv_msb,
	// Outputs
	input wire dcwd_pkg::dcwd_nco_sel_type nco_sel,
	input wire logic                       accum_clear,
	input wire logic                       accum_clk_en,
	input wire logic                       converter_powerdown,
	input wire logic                       converter_to_pin,
	input wire logic                       ramp_mode,
	input wire logic                       pin_bit
);
	import dcwd_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Control write, seen at sampled outputs two edges later, at ramp_mode one edge later
	sequence s_ctl;
		word_valid && word_in.addr == ADDR_CTRL;
	endsequence
	// Pipe running long enough that a change has a clean cause
	sequence s_run;
		accum_clk_en [*8] ##1 (accum_clk_en && $changed(nco_sel));
	endsequence
	property p_clr; s_ctl |-> ##2 accum_clear == $past(word_in.payload[8], 2); endproperty
	property p_en; s_ctl |-> ##2 accum_clk_en == !$past(word_in.payload[7], 2); endproperty
	property p_pd; s_ctl |-> ##2 converter_powerdown == $past(word_in.payload[6], 2); endproperty
	property p_pin; s_ctl |-> ##2 converter_to_pin == !$past(word_in.payload[5], 2); endproperty
	property p_mode; s_ctl |-> ##1 ramp_mode == $past(word_in.payload[1]); endproperty
	property p_cause;
		$changed(converter_powerdown) |-> $past(word_valid && word_in.addr == ADDR_CTRL, 2);
	endproperty
	property p_frz; !accum_clk_en [*3] |=> $stable(nco_sel); endproperty
	// Data writes show after eight samples, select changes one later
	property p_lat;
		s_run |-> ($past(word_valid && word_in.addr != ADDR_CTRL, 8) ||
			$past(word_valid && word_in.addr == ADDR_CTRL, 9));
	endproperty
	// Pin bit stays low while the converter owns the pin
	property p_pinlow; converter_to_pin |=> !pin_bit; endproperty
	a_clr: assert property (p_clr) else $error("accum_clear wrong");
	a_en: assert property (p_en) else $error("accum_clk_en wrong");
	a_pd: assert property (p_pd) else $error("powerdown wrong");
	a_pin: assert property (p_pin) else $error("pin route wrong");
	a_mode: assert property (p_mode) else $error("mode bit wrong");
	a_cause: assert property (p_cause) else $error("control change uncaused");
	a_frz: assert property (p_frz) else $error("selection moved while halted");
	a_lat: assert property (p_lat) else $error("selection latency wrong");
	a_pinlow: assert property (p_pinlow) else $error("pin bit set while unrouted");
endmodule : dcwd_checker
bind dds_control_word_decoder dcwd_checker i_chk (
	.clk                 (clk),
	.sys_rst             (sys_rst),
	.word_valid          (word_valid),
	.word_in             (word_in),
	.conv_msb            (conv_msb),
	.nco_sel             (nco_sel),
	.accum_clear         (accum_clear),
	.accum_clk_en        (accum_clk_en),
	.converter_powerdown (converter_powerdown),
	.converter_to_pin    (converter_to_pin),
	.ramp_mode           (ramp_mode),
	.pin_bit             (pin_bit)
);
`default_nettype wire

// [testbench/test_dds_control_word_decoder.sv]
// Directed tests of the control word decoder
`timescale 1ns/100ps
`default_nettype none
module test_dds_control_word_decoder;
	import dcwd_pkg::*;
	// Bench signals
	logic             clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic             conv_msb = 1'b0;
	logic             word_valid;
	dcwd_word_type    word_in;
	dcwd_nco_sel_type nco_sel;
	logic             accum_clear, accum_clk_en, converter_powerdown;
	logic             converter_to_pin, ramp_mode, pin_bit;
	int               n_mismatch = 0;
	int               total_checks = 0;
	logic [15:0]      ctl_tab [5] = '{16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0002};
	// 100 ns period
	always #50 clk = ~clk;
	dds_control_word_decoder i_dut (
		.clk                 (clk),
		.sys_rst             (sys_rst),
		.word_valid          (word_valid),
		.word_in             (word_in),
		.conv_msb            (conv_msb),
		.nco_sel             (nco_sel),
		.accum_clear         (accum_clear),
		.accum_clk_en        (accum_clk_en),
		.converter_powerdown (converter_powerdown),
		.converter_to_pin    (converter_to_pin),
		.ramp_mode           (ramp_mode),
		.pin_bit             (pin_bit)
	);
	dcwd_host_model i_host (.clk(clk), .word_valid(word_valid), .word_in(word_in));
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Write one word, then wait past the eight-cycle latency
	task wr(input logic [15:0] w);
		i_host.send(w);
		repeat (10) @(negedge clk);
	endtask : wr
	task test_done;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done
	// Main sequence
	initial begin
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		chk(accum_clear, 1'b1);
		wr(16'h3000);
		chk(accum_clear, 1'b0);
		wr(16'h4001);
		chk(nco_sel.freq, 28'h0);
		wr(16'h4002);
		chk(nco_sel.freq, 28'h0008001);
		i_host.send(16'h4abc);
		wr(16'h1000);
		chk(nco_sel.freq, 28'h0008001);
		wr(16'h4003);
		chk(nco_sel.freq, 28'h000c001);
		wr(16'h0000);
		wr(16'h4005);
		wr(16'h8007);
		chk(nco_sel.freq, 28'h000c005);
		wr(16'he00f);
		wr(16'h0c00);
		chk(nco_sel, {28'h0000007, 12'h00f});
		// Phase word a written while unselected, then selected
		wr(16'hc0aa);
		wr(16'h0800);
		chk(nco_sel, {28'h0000007, 12'h0aa});
		// Select bits kept so the table only moves control levels
		foreach (ctl_tab[i]) begin
			wr(ctl_tab[i] | 16'h0c00);
			chk({accum_clear, accum_clk_en, converter_powerdown, converter_to_pin, ramp_mode},
				{ctl_tab[i][8], !ctl_tab[i][7], ctl_tab[i][6], !ctl_tab[i][5],
				ctl_tab[i][1]});
		end
		wr(16'h0c28);
		conv_msb = 1'b1;
		repeat (3) @(negedge clk);
		chk(pin_bit, 1'b1);
		conv_msb = 1'b0;
		repeat (3) @(negedge clk);
		chk(pin_bit, 1'b0);
		// Halved MSB: cleared by reset, flips on each rising MSB
		wr(16'h0d20);
		chk(pin_bit, 1'b0);
		wr(16'h0c20);
		conv_msb = 1'b1;
		repeat (3) @(negedge clk);
		chk(pin_bit, 1'b1);
		conv_msb = 1'b0;
		repeat (3) @(negedge clk);
		chk(pin_bit, 1'b1);
		conv_msb = 1'b1;
		repeat (3) @(negedge clk);
		chk(pin_bit, 1'b0);
		test_done;
	end
	// Watchdog
	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end
endmodule : test_dds_control_word_decoder
`default_nettype wire
